// *** fan_loop_pkg.sv ***
package fan_loop_pkg;

  // Command codes for register reads and writes
  localparam logic [7:0] CMD_RD_SPEED  = 8'hAB;
  localparam logic [7:0] CMD_WR_SPEED  = 8'hB4;
  localparam logic [7:0] CMD_RD_GAIN   = 8'hAD;
  localparam logic [7:0] CMD_WR_GAIN   = 8'hB6;
  localparam logic [7:0] CMD_RD_TDIV   = 8'hBB;
  localparam logic [7:0] CMD_WR_TDIV   = 8'hBC;
  localparam logic [7:0] CMD_RD_FSDIV  = 8'hBF;
  localparam logic [7:0] CMD_WR_FSDIV  = 8'hC0;
  localparam logic [7:0] CMD_RD_LIMIT  = 8'hB1;
  localparam logic [7:0] CMD_WR_LIMIT  = 8'hB8;

  // Reset values
  localparam logic [7:0] SPEED_RST     = 8'h00;
  localparam logic [7:0] GAIN_RST      = 8'h80;
  localparam logic [7:0] TDIV_RST      = 8'h01;
  localparam logic [7:0] FSDIV_RST     = 8'hFF;
  localparam logic [7:0] LIMIT_RST     = 8'hFF;
  localparam logic [7:0] RATE_RST      = 8'h02;

  // Field positions in loop_gain
  localparam int GAIN_OPEN_BIT  = 0;
  localparam int GAIN_CSENSE_BIT = 1;
  localparam int GAIN_SPAN_LO   = 5;
  localparam int GAIN_KEEP_BIT  = 7;

  // Speed codes, divider minimum and fastest rate code
  localparam logic [6:0] FULL_4BIT     = 7'h10;
  localparam logic [6:0] FULL_5BIT     = 7'h20;
  localparam logic [6:0] FULL_6BIT     = 7'h3F;
  localparam logic [6:0] OPEN_FORCE    = 7'h40;
  localparam logic [7:0] FSDIV_MIN     = 8'd127;
  localparam logic [2:0] RATE_FASTEST  = 3'd6;

  // Timing
  localparam longint CLK_HZ            = 250_000_000;
  localparam longint REF_HZ            = 8415;
  localparam int     REF_DIV_CYC       = int'(CLK_HZ / REF_HZ);
  localparam longint UPDATE_BASE_MS    = 250;
  localparam int     UPDATE_BASE_CYC   = int'(CLK_HZ / 1000 * UPDATE_BASE_MS);

endpackage

// *** fan_prescaler.sv ***
module fan_prescaler
  import fan_loop_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       pulse_in,
  input  wire logic [1:0] ratio_sel,
  output logic            pulse_out
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       out;
  } pre_state_t;

  pre_state_t s_q;
  pre_state_t s_d;

  // Pass every 1st, 2nd, 4th or 8th input pulse
  always_comb begin
    logic [2:0] last;
    last = 3'((4'd1 << ratio_sel) - 4'd1);
    s_d = s_q;
    s_d.out = 1'b0;
    if (pulse_in) begin
      if (s_q.cnt >= last) begin
        s_d.cnt = 3'd0;
        s_d.out = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 3'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_out = s_q.out;

endmodule

// *** fan_speed_regulation_loop.sv ***
// Operation
// - Open loop: speed_setting 0..40h sets voltage
// - Open: 0..3Fh proportional, 40h forces full
// - Closed: full speed 10h/20h/3Fh by gain
// - Counter up on reference, down on feedback
// - Reference derived from clock at 8415Hz
// - Divide by full_scale_divider, minimum 127
// - Further scale by speed_setting over full-speed code
// - Feedback prescaled by 1, 2, 4, 8
// - Six-stage counter drives 6-bit fan DAC
// - loop_gain bit 0 selects open loop
// - Open loop ignores feedback, opens thermal loop
// - Fan-fail reads 1 while loop open
// - loop_gain bit 1 selects current sensing
// - loop_gain bits 6:5 set control span
// - Write with bit 7 low clears span
// - update_rate uses low three bits, reset 02h
// - Codes 0..6 give 16s down to 0.25s
// - Driver off above 150C, on below 140C
// - Current step makes one feedback pulse
// - Period counter loads tach_period on pulse
// - Fail when period exceeds limit; full flag
// - Period overflow ORed into fan-fail
// - Thermal closed: speed_setting holds saturated excess
// - Config bit 3 opens thermal loop
module fan_speed_regulation_loop
  import fan_loop_pkg::*;
#(
  parameter int REF_DIV    = REF_DIV_CYC,
  parameter int UPDATE_DIV = UPDATE_BASE_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_wr_addr,
  input  wire logic [7:0] cmd_wr_data,
  input  wire logic [7:0] cmd_rd_addr,
  output logic      [7:0] cmd_rd_data,
  input  wire logic       update_rate_wr,
  input  wire logic [7:0] update_rate_wdata,
  output logic      [7:0] update_rate,
  input  wire logic       thermal_open_cfg,
  input  wire logic [8:0] temp_excess,
  input  wire logic       tach_in,
  input  wire logic       current_step,
  input  wire logic       driver_over_150,
  input  wire logic       driver_below_140,
  output logic      [5:0] fan_dac_code,
  output logic            fan_full_on,
  output logic            fan_driver_en,
  output logic            driver_overheat,
  output logic            thermal_open,
  output logic            fan_fail,
  output logic            fan_full_scale,
  output logic      [7:0] tach_period
);

  typedef struct packed {
    logic [7:0]  speed_setting;
    logic [7:0]  loop_gain;
    logic [7:0]  tach_divisor;
    logic [7:0]  full_scale_divider;
    logic [7:0]  tach_period_limit;
    logic [7:0]  update_rate;
    logic [7:0]  tach_period;
    logic [7:0]  rd_data;
    logic [5:0]  speed_counter;
    logic [31:0] ref_cnt;
    logic [15:0] rate_acc;
    logic [31:0] quarter_cnt;
    logic [6:0]  quarter_num;
    logic [7:0]  period_cnt;
    logic        period_ovf;
    logic        tach_q;
    logic        shutdown;
    logic        dac_full;
    logic [5:0]  dac_code;
    logic        fail;
    logic        full_flag;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Full-speed code for the selected span
  function automatic logic [6:0] full_code(input logic [1:0] span);
    case (span)
      2'b00:   full_code = FULL_4BIT;
      2'b01:   full_code = FULL_5BIT;
      default: full_code = FULL_6BIT;
    endcase
  endfunction

  // Smaller of two codes
  function automatic logic [6:0] min_code(input logic [6:0] a, input logic [6:0] b);
    min_code = (a < b) ? a : b;
  endfunction

  logic       fan_open;
  logic       tach_edge;
  logic       fb_raw;
  logic       fb_pulse;
  logic [6:0] full_c;
  logic [6:0] target;
  logic [7:0] fs_eff;
  logic [15:0] threshold;
  logic       ref_tick;
  logic       quarter_tick;
  logic [6:0] quarters_needed;
  logic       update_tick;
  logic       up_pulse;

  // Mode decode and feedback selection
  assign fan_open  = s_q.loop_gain[GAIN_OPEN_BIT];
  assign tach_edge = tach_in & ~s_q.tach_q;
  assign fb_raw    = fan_open ? 1'b0 :
                     (s_q.loop_gain[GAIN_CSENSE_BIT] ? current_step : tach_edge);

  fan_prescaler u_prescaler (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pulse_in  (fb_raw),
    .ratio_sel (s_q.tach_divisor[1:0]),
    .pulse_out (fb_pulse)
  );

  // Reference rate arithmetic
  assign full_c    = full_code(s_q.loop_gain[GAIN_SPAN_LO +: 2]);
  assign target    = min_code(s_q.speed_setting[6:0], full_c);
  assign fs_eff    = (s_q.full_scale_divider < FSDIV_MIN) ? FSDIV_MIN
                                                          : s_q.full_scale_divider;
  assign threshold = 16'(full_c) * 16'(fs_eff);                                   // Widen before the product
  assign ref_tick  = (s_q.ref_cnt == 32'(REF_DIV - 1));
  assign quarter_tick = (s_q.quarter_cnt == 32'(UPDATE_DIV - 1));

  // Number of quarter seconds between updates
  always_comb begin
    logic [2:0] code;
    code = s_q.update_rate[2:0];
    if (code > RATE_FASTEST) begin
      code = RATE_FASTEST;
    end
    quarters_needed = 7'(7'd1 << (RATE_FASTEST - code));
  end

  assign update_tick = quarter_tick && (s_q.quarter_num >= quarters_needed - 7'd1);
  assign up_pulse    = ref_tick && ((s_q.rate_acc + 16'(target)) >= threshold)
                       && (target != 7'd0);

  // Next-state logic
  always_comb begin
    logic [7:0] excess;
    excess = (temp_excess > 9'h07F) ? 8'h7F : {1'b0, temp_excess[6:0]};
    s_d = s_q;
    s_d.tach_q = tach_in;

    // Reference prescaler and update timers
    s_d.ref_cnt = ref_tick ? 32'd0 : s_q.ref_cnt + 32'd1;
    if (quarter_tick) begin
      s_d.quarter_cnt = 32'd0;
      s_d.quarter_num = update_tick ? 7'd0 : s_q.quarter_num + 7'd1;
    end else begin
      s_d.quarter_cnt = s_q.quarter_cnt + 32'd1;
    end

    // Fractional divider: reference scaled by target over full speed
    if (ref_tick) begin
      if (up_pulse) begin
        s_d.rate_acc = s_q.rate_acc + 16'(target) - threshold;
      end else if (target != 7'd0) begin
        s_d.rate_acc = s_q.rate_acc + 16'(target);
      end else begin
        s_d.rate_acc = 16'd0;
      end
    end

    // Up/down speed counter, saturating at both ends
    if (fan_open) begin
      s_d.speed_counter = 6'd0;
      s_d.rate_acc = 16'd0;
    end else if (up_pulse && !fb_pulse) begin
      if (s_q.speed_counter != 6'h3F) begin
        s_d.speed_counter = s_q.speed_counter + 6'd1;
      end
    end else if (fb_pulse && !up_pulse) begin
      if (s_q.speed_counter != 6'h00) begin
        s_d.speed_counter = s_q.speed_counter - 6'd1;
      end
    end

    // DAC code: direct in open loop, counter in closed loop
    if (fan_open) begin
      s_d.dac_full = (s_q.speed_setting[6:0] >= OPEN_FORCE);
      s_d.dac_code = s_d.dac_full ? 6'h3F : s_q.speed_setting[5:0];
    end else begin
      s_d.dac_full = 1'b0;
      s_d.dac_code = s_q.speed_counter;
    end

    // Driver thermal shutdown with hysteresis
    if (driver_over_150) begin
      s_d.shutdown = 1'b1;
    end else if (driver_below_140) begin
      s_d.shutdown = 1'b0;
    end

    // Period counter on the reference oscillator
    if (fb_pulse) begin
      s_d.tach_period = s_q.period_cnt;
      s_d.period_cnt  = 8'd0;
      s_d.period_ovf  = 1'b0;
    end else if (ref_tick) begin
      if (s_q.period_cnt == 8'hFF) begin
        s_d.period_ovf = 1'b1;
      end else begin
        s_d.period_cnt = s_q.period_cnt + 8'd1;
      end
    end
    if (fan_open) begin
      s_d.period_cnt = 8'd0;
      s_d.period_ovf = 1'b0;
    end

    // Fan-fail and full-speed status
    s_d.fail = fan_open ? 1'b1 :
               ((s_q.tach_period > s_q.tach_period_limit) || s_q.period_ovf);
    s_d.full_flag = !fan_open && (s_q.speed_counter == 6'h3F);

    // Thermal closed loop loads the saturated excess at each update
    if (!thermal_open && update_tick) begin
      s_d.speed_setting = excess;
    end

    // Register writes
    if (cmd_wr) begin
      case (cmd_wr_addr)
        CMD_WR_SPEED: begin
          if (thermal_open) begin
            s_d.speed_setting = {1'b0, cmd_wr_data[6:0]};
          end
        end
        CMD_WR_GAIN: begin
          s_d.loop_gain = cmd_wr_data;
          if (!cmd_wr_data[GAIN_KEEP_BIT]) begin
            s_d.loop_gain[GAIN_SPAN_LO +: 2] = 2'b00;
          end
        end
        CMD_WR_TDIV:  s_d.tach_divisor = cmd_wr_data;
        CMD_WR_FSDIV: s_d.full_scale_divider = cmd_wr_data;
        CMD_WR_LIMIT: s_d.tach_period_limit = cmd_wr_data;
        default: ;
      endcase
    end
    if (update_rate_wr) begin
      s_d.update_rate = update_rate_wdata;
    end

    // Register reads, answered one cycle later
    case (cmd_rd_addr)
      CMD_RD_SPEED: s_d.rd_data = s_q.speed_setting;
      CMD_RD_GAIN:  s_d.rd_data = s_q.loop_gain;
      CMD_RD_TDIV:  s_d.rd_data = s_q.tach_divisor;
      CMD_RD_FSDIV: s_d.rd_data = s_q.full_scale_divider;
      CMD_RD_LIMIT: s_d.rd_data = s_q.tach_period_limit;
      default:      s_d.rd_data = 8'h00;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.speed_setting      <= SPEED_RST;
      s_q.loop_gain          <= GAIN_RST;
      s_q.tach_divisor       <= TDIV_RST;
      s_q.full_scale_divider <= FSDIV_RST;
      s_q.tach_period_limit  <= LIMIT_RST;
      s_q.update_rate        <= RATE_RST;
      s_q.tach_q             <= 1'b1;  // Idle level of the pulled-up tach line, no false edge
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign thermal_open    = thermal_open_cfg | fan_open;
  assign cmd_rd_data     = s_q.rd_data;
  assign update_rate     = s_q.update_rate;
  assign fan_dac_code    = s_q.shutdown ? 6'h00 : s_q.dac_code;
  assign fan_full_on     = s_q.dac_full & ~s_q.shutdown;
  assign fan_driver_en   = ~s_q.shutdown;
  assign driver_overheat = s_q.shutdown;
  assign fan_fail        = s_q.fail;
  assign fan_full_scale  = s_q.full_flag;
  assign tach_period     = s_q.tach_period;

endmodule

// *** fan_loop_asserts.sv ***
module fan_loop_asserts
  import fan_loop_pkg::*;
#(
  parameter int REF_DIV    = 8,
  parameter int UPDATE_DIV = 16
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       update_rate_wr,
  input wire logic [7:0] update_rate_wdata,
  input wire logic [7:0] update_rate,
  input wire logic       thermal_open_cfg,
  input wire logic       driver_over_150,
  input wire logic       driver_below_140,
  input wire logic [5:0] fan_dac_code,
  input wire logic       fan_full_on,
  input wire logic       fan_driver_en,
  input wire logic       driver_overheat,
  input wire logic       thermal_open,
  input wire logic       fan_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Driver held off by thermal shutdown
  sequence s_off;
    !fan_driver_en && driver_overheat;
  endsequence

  // Fan loop opened by the gain register alone
  sequence s_fan_open;
    thermal_open && !thermal_open_cfg;
  endsequence

  AST_TRIP: assert property (driver_over_150 |=> s_off)
    else $error("driver not shut down after overheat");
  AST_HOLD_OFF: assert property (driver_overheat && !driver_below_140 |=> s_off)
    else $error("driver restarted before cooling");
  AST_RELEASE: assert property (s_off and driver_below_140 && !driver_over_150 |=> fan_driver_en)
    else $error("driver not restarted after cooling");
  AST_DAC_OFF: assert property (s_off ##1 s_off |-> fan_dac_code == 6'h00)
    else $error("dac drives fan during shutdown");
  AST_OPEN_FAIL: assert property (s_fan_open |=> fan_fail)
    else $error("fan fail low in open loop");
  AST_OPEN_THERM: assert property (thermal_open_cfg |-> thermal_open)
    else $error("thermal loop not open");
  AST_FULL_ON: assert property (fan_full_on |-> fan_dac_code == 6'h3F)
    else $error("full on without full dac code");
  AST_DAC_STEP: assert property (!thermal_open && $past(thermal_open, 2) == 1'b0 && $past(!thermal_open)
    && fan_driver_en && $past(fan_driver_en) |-> fan_dac_code == $past(fan_dac_code)
    || fan_dac_code == $past(fan_dac_code) + 6'h01 || fan_dac_code == $past(fan_dac_code) - 6'h01)
    else $error("closed loop dac jumped");
  AST_RATE: assert property (update_rate_wr |=> update_rate[2:0] == $past(update_rate_wdata[2:0]))
    else $error("update rate low bits not stored");
endmodule

bind fan_speed_regulation_loop fan_loop_asserts #(
  .REF_DIV    (REF_DIV),
  .UPDATE_DIV (UPDATE_DIV)
) u_chk (
  .clk_sys           (clk_sys),
  .rst               (rst),
  .update_rate_wr    (update_rate_wr),
  .update_rate_wdata (update_rate_wdata),
  .update_rate       (update_rate),
  .thermal_open_cfg  (thermal_open_cfg),
  .driver_over_150   (driver_over_150),
  .driver_below_140  (driver_below_140),
  .fan_dac_code      (fan_dac_code),
  .fan_full_on       (fan_full_on),
  .fan_driver_en     (fan_driver_en),
  .driver_overheat   (driver_overheat),
  .thermal_open      (thermal_open),
  .fan_fail          (fan_fail)
);

// *** fan_model.sv ***
module fan_model (
  input  wire logic       clk_sys,
  input  wire logic [5:0] fan_dac_code,
  input  wire logic       fan_driver_en,
  output logic            tach_in = 1'b1,
  output logic            current_step = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // Tach toggles faster with more drive; a stopped fan leaves the pulled-up line high
  always @(posedge clk_sys) begin
    current_step <= 1'b0;
    if (!fan_driver_en || fan_dac_code == 6'h00) begin
      tach_in <= 1'b1;
    end else if (cnt >= 1000 / int'(fan_dac_code)) begin
      cnt <= 0;
      tach_in <= ~tach_in;
      current_step <= ~tach_in; // Current rises with each commutation that drives tach high
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fan_loop_pkg::*;

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

  logic       clk_sys, rst, cmd_wr, update_rate_wr, thermal_open_cfg, tach_in, current_step;
  logic       driver_over_150, driver_below_140, fan_full_on, fan_driver_en, driver_overheat;
  logic       thermal_open, fan_fail, fan_full_scale;
  logic [7:0] cmd_wr_addr, cmd_wr_data, cmd_rd_addr, cmd_rd_data, update_rate_wdata, update_rate;
  logic [7:0] tach_period;
  logic [8:0] temp_excess;
  logic [5:0] fan_dac_code;
  int         fail_count = 0;
  int         checked = 0;
  int         cyc = 0;
  logic [7:0] ra_tab [5] = '{CMD_RD_SPEED, CMD_RD_GAIN, CMD_RD_TDIV, CMD_RD_FSDIV, CMD_RD_LIMIT};
  logic [7:0] rv_tab [5] = '{8'h00, 8'h80, 8'h01, 8'hFF, 8'hFF};
  logic [7:0] dac_tab [3] = '{8'h00, 8'h2A, 8'h3F};

  fan_speed_regulation_loop #(.REF_DIV(8), .UPDATE_DIV(16)) u_dut (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .cmd_wr            (cmd_wr),
    .cmd_wr_addr       (cmd_wr_addr),
    .cmd_wr_data       (cmd_wr_data),
    .cmd_rd_addr       (cmd_rd_addr),
    .cmd_rd_data       (cmd_rd_data),
    .update_rate_wr    (update_rate_wr),
    .update_rate_wdata (update_rate_wdata),
    .update_rate       (update_rate),
    .thermal_open_cfg  (thermal_open_cfg),
    .temp_excess       (temp_excess),
    .tach_in           (tach_in),
    .current_step      (current_step),
    .driver_over_150   (driver_over_150),
    .driver_below_140  (driver_below_140),
    .fan_dac_code      (fan_dac_code),
    .fan_full_on       (fan_full_on),
    .fan_driver_en     (fan_driver_en),
    .driver_overheat   (driver_overheat),
    .thermal_open      (thermal_open),
    .fan_fail          (fan_fail),
    .fan_full_scale    (fan_full_scale),
    .tach_period       (tach_period)
  );
  fan_model u_fan (.clk_sys(clk_sys), .fan_dac_code(fan_dac_code), .fan_driver_en(fan_driver_en),
    .tach_in(tach_in), .current_step(current_step));

  // Clock at 250 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Register write, one-cycle strobe launched at a falling edge, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd_wr_addr = a;
    cmd_wr_data = d;
    cmd_wr = 1'b1;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  // Register read with a field mask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    cmd_rd_addr = a;
    repeat (2) @(negedge clk_sys);
    `CHK(cmd_rd_data & m, e)
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      complete_run();
    end
  end

  // Test sequence
  initial begin
    {rst, cmd_wr, update_rate_wr, thermal_open_cfg, driver_over_150, driver_below_140} = 6'h20;
    {cmd_wr_addr, cmd_wr_data, cmd_rd_addr, update_rate_wdata} = 32'h0000_0000;
    temp_excess = 9'h000;
    idle(10);
    rst = 1'b0;
    foreach (ra_tab[i]) rd(ra_tab[i], 8'hFF, rv_tab[i]);
    `CHK(update_rate, 8'h02)
    $display("test reset done");
    wr(CMD_WR_GAIN, 8'hC0);
    rd(CMD_RD_GAIN, 8'hFF, 8'hC0);
    wr(CMD_WR_GAIN, 8'h40);
    rd(CMD_RD_GAIN, 8'h60, 8'h00);
    wr(CMD_WR_GAIN, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(CMD_WR_TDIV, 8'(i));
      rd(CMD_RD_TDIV, 8'h03, 8'(i));
    end
    wr(CMD_WR_TDIV, 8'h01);
    update_rate_wdata = 8'hFF;
    update_rate_wr = 1'b1;
    idle(1);
    update_rate_wr = 1'b0;
    idle(1);
    `CHK(update_rate[2:0], 3'h7)
    $display("test registers done");
    wr(CMD_WR_SPEED, 8'h15);
    rd(CMD_RD_SPEED, 8'hFF, 8'h00);
    temp_excess = 9'h1FF;
    idle(40);
    rd(CMD_RD_SPEED, 8'hFF, 8'h7F);
    temp_excess = 9'h011;
    idle(40);
    rd(CMD_RD_SPEED, 8'hFF, 8'h11);
    $display("test thermal loop done");
    wr(CMD_WR_GAIN, 8'h81);
    idle(3);
    `CHK(thermal_open, 1'b1)
    `CHK(fan_fail, 1'b1)
    `CHK(fan_full_scale, 1'b0)
    foreach (dac_tab[i]) begin
      wr(CMD_WR_SPEED, dac_tab[i]);
      idle(300);
      `CHK(fan_dac_code, dac_tab[i][5:0])
      `CHK(fan_full_on, 1'b0)
    end
    wr(CMD_WR_SPEED, 8'h40);
    idle(3);
    `CHK(fan_dac_code, 6'h3F)
    `CHK(fan_full_on, 1'b1)
    $display("test open loop done");
    driver_over_150 = 1'b1;
    idle(2);
    driver_over_150 = 1'b0;
    idle(3);
    `CHK(fan_driver_en, 1'b0)
    `CHK(driver_overheat, 1'b1)
    `CHK(fan_dac_code, 6'h00)
    driver_below_140 = 1'b1;
    idle(3);
    driver_below_140 = 1'b0;
    `CHK(fan_driver_en, 1'b1)
    `CHK(driver_overheat, 1'b0)
    $display("test shutdown done");
    thermal_open_cfg = 1'b1;
    wr(CMD_WR_FSDIV, 8'h10);
    wr(CMD_WR_GAIN, 8'hA0);
    wr(CMD_WR_SPEED, 8'h20);
    idle(4000);
    `CHK(fan_dac_code == 6'h00, 1'b0)
    `CHK(tach_period == 8'h00, 1'b0)
    wr(CMD_WR_GAIN, 8'hA2);
    wr(CMD_WR_SPEED, 8'h00);
    idle(30000);
    `CHK(fan_dac_code, 6'h00)
    $display("test closed loop done");
    complete_run();
  end
endmodule
